// file: hdl/lut16x1.v
// one lookup-table memory element: sixteen words of one bit
`timescale 1ns/1ps

module lut16x1
(
   input wire pclk,
   input wire we,
   input wire [3:0] waddr,
   input wire wd,
   input wire [3:0] raddr,
   output wire rd
);

   reg [15:0] mem_r;

   // ====================================================================
   // storage
   // contents are not reset: a lookup table holds whatever was written last
   always @(posedge pclk)
   begin
      if (we)
      begin
         mem_r[waddr] <= wd; // [RULE_01] [RULE_13]
      end
   end

   // read follows the address with no clock in between
   assign rd = mem_r[raddr]; // [RULE_04]

endmodule // lut16x1

// file: hdl/slice_lut_ram.v
// slice lookup-table memory cluster with storage element and apb access
// Summary of operation
// [RULE_01] each lookup table is a sixteen word by one bit synchronous memory
// [RULE_02] tables gang into single-port 16x8, 32x4, 64x2 or 128x1 memories
// [RULE_03] tables gang into dual-port 16x4, 32x2 or 64x1 memories
// [RULE_04] writes commit on the clock edge; reads follow the address at once
// [RULE_05] read data may be registered in the storage element, same clock
// [RULE_06] write enable is active high, taken from the slice set/reset input
// [RULE_07] table use: 16x1 1 or 2, 32x1 2 or 4, 64x1 4 or 8, 128x1 8
// [RULE_08] storage offers none, sync set/reset/both, async preset/clear/both
// [RULE_09] sync reset and set together give the reset value
// [RULE_10] async clear and preset together give the cleared value
// [RULE_11] single-port shapes read and write through one address bus
// [RULE_12] dual-port copy reads its own address, writes at the shared address
// [RULE_13] a write stores the data at the address; otherwise contents stay
`timescale 1ns/1ps
`include "slice_storage_map.vh"

module slice_lut_ram
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [6:0] ram_addr,
   input wire [5:0] ram_rd_addr,
   input wire [7:0] ram_wdata,
   input wire slice_set_reset_input,
   input wire [11:0] store_d,
   input wire store_ce,
   input wire store_set,
   input wire store_reset,
   input wire store_preset,
   input wire store_clear,
   output wire [11:0] store_q
);

   // ====================================================================
   // declarations
   reg [`SS_CTRL_BITS-1:0] ctrl_r;
   wire [1:0] depth_log;
   wire [1:0] width_log;
   wire dual;
   wire reg_read;
   wire [2:0] shape_log;
   wire cfg_ok;
   wire [7:0] units;
   wire [7:0] total;
   wire [2:0] bank_mask;
   wire [2:0] a_bank;
   wire [2:0] r_bank;
   wire wr_ok;
   wire [3:0] word_addr;
   wire [3:0] rd_word;
   wire [3:0] luts_used;
   wire sset_en;
   wire srst_en;
   wire apre_en;
   wire aclr_en;
   wire [`SS_LUTS-1:0] lut_we;
   wire [`SS_LUTS-1:0] lut_wd;
   wire [`SS_LUTS-1:0] lut_rd;
   wire [31:0] lut_ra;
   reg [7:0] sp_data;
   reg [3:0] dp_data;
   wire [11:0] store_in;
   wire setup;
   wire access_wr;
   wire ctrl_wr;
   reg [31:0] rd_nxt;
   reg err_nxt;
   integer b;
   reg [7:0] pos;
   integer bd;
   reg [7:0] dpos;

   // ====================================================================
   // shape decode
   assign depth_log = ctrl_r[`SS_CTRL_DEPTH_MSB:`SS_CTRL_DEPTH_LSB];
   assign width_log = ctrl_r[`SS_CTRL_WIDTH_MSB:`SS_CTRL_WIDTH_LSB];
   assign dual = ctrl_r[`SS_CTRL_DUAL];
   assign reg_read = ctrl_r[`SS_CTRL_REG_READ];
   assign shape_log = {1'b0, depth_log} + {1'b0, width_log};

   // a shape fits the cluster only if its tables, doubled for dual port, fit
   assign cfg_ok = dual ? (shape_log <= 3'd`SS_DP_MAX_LOG) :
      (shape_log <= 3'd`SS_SP_MAX_LOG); // [RULE_02] [RULE_03]

   // tables per copy is depth/16 times width; a dual copy doubles it
   assign units = 8'd1 << shape_log; // [RULE_07]
   assign total = dual ? {units[6:0], 1'b0} : units; // [RULE_07]

   // table count shown to software; an unfit shape occupies nothing
   assign luts_used = cfg_ok ? total[3:0] : 4'h0; // [RULE_07]

   // upper address bits pick the table within one data bit
   assign bank_mask = ~(3'h7 << depth_log);
   assign a_bank = ram_addr[6:4] & bank_mask;
   assign r_bank = {1'b0, ram_rd_addr[5:4]} & bank_mask;

   // low address bits pick the word inside every table
   assign word_addr = ram_addr[3:0]; // [RULE_11]
   assign rd_word = ram_rd_addr[3:0]; // [RULE_12]

   // writes are refused while the shape does not fit, so no table is
   // corrupted by a half-mapped configuration
   assign wr_ok = slice_set_reset_input & cfg_ok; // [RULE_06]

   // ====================================================================
   // table array: per-table write select, write bit and read address
   genvar i;
   generate
      for (i = 0; i < `SS_LUTS; i = i + 1)
      begin : g_lut
         wire [31:0] li_full;
         wire [7:0] li;
         wire copy;
         wire [7:0] idx;
         wire used;
         wire hit;
         wire [7:0] bsel;

         // loop index, cut to the width of a table number
         assign li_full = i;
         assign li = li_full[7:0];
         // tables above the primary copy hold the second read copy
         assign copy = dual & (li >= units); // [RULE_12]
         assign idx = copy ? li - units : li;
         assign used = li < total; // [RULE_07]
         assign hit = (idx[2:0] & bank_mask) == a_bank;
         assign bsel = idx >> depth_log;

         // both copies see every write at the shared address
         assign lut_we[i] = wr_ok & used & hit; // [RULE_12] [RULE_13]
         assign lut_wd[i] = ram_wdata[bsel[2:0]];
         // single port: read address is the write address
         assign lut_ra[i*4+3:i*4] = copy ? rd_word : word_addr; // [RULE_11] [RULE_12]

         lut16x1 u_lut
         (
            .pclk(pclk),
            .we(lut_we[i]),
            .waddr(word_addr),
            .wd(lut_wd[i]),
            .raddr(lut_ra[i*4+3:i*4]),
            .rd(lut_rd[i])
         );
      end
   endgenerate

   // ====================================================================
   // single-port read word; unused bits above the shape width read as zero
   always @*
   begin
      sp_data = 8'h00;
      pos = 8'h00;
      for (b = 0; b < 8; b = b + 1)
      begin
         if ((b < (1 << width_log)) && cfg_ok)
         begin
            pos = ({5'h00, b[2:0]} << depth_log) | {5'h00, a_bank};
            sp_data[b] = lut_rd[pos[2:0]]; // [RULE_04] [RULE_11]
         end
      end
   end

   // dual-port read word from the copy tables, addressed by the read-only port
   always @*
   begin
      dp_data = 4'h0;
      dpos = 8'h00;
      for (bd = 0; bd < 4; bd = bd + 1)
      begin
         if ((bd < (1 << width_log)) && cfg_ok && dual)
         begin
            dpos = units + (({5'h00, bd[2:0]} << depth_log) | {5'h00, r_bank});
            dp_data[bd] = lut_rd[dpos[2:0]]; // [RULE_04] [RULE_12]
         end
      end
   end

   // ====================================================================
   // storage element: registered read or plain user data
   // in registered-read mode the element captures every clock, so the read
   // costs exactly one cycle of latency on the same clock as the writes
   assign store_in = reg_read ? {dp_data, sp_data} : store_d; // [RULE_05]

   // storage option enables; only reset and a control register write move them
   assign sset_en = ctrl_r[`SS_CTRL_SYNC_SET]; // [RULE_08]
   assign srst_en = ctrl_r[`SS_CTRL_SYNC_RST]; // [RULE_08]
   assign apre_en = ctrl_r[`SS_CTRL_ASYNC_PRE]; // [RULE_08]
   assign aclr_en = ctrl_r[`SS_CTRL_ASYNC_CLR]; // [RULE_08]

   slice_store_elem
   #(
      .WIDTH(12)
   )
   u_store
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(store_in),
      .ce(store_ce | reg_read), // [RULE_05]
      .sync_set_en(sset_en),
      .sync_rst_en(srst_en),
      .async_pre_en(apre_en),
      .async_clr_en(aclr_en),
      .set_in(store_set),
      .rst_in(store_reset),
      .pre_in(store_preset),
      .clr_in(store_clear),
      .q(store_q)
   );

   // ====================================================================
   // apb slave: zero wait states, read data captured in the setup cycle
   assign setup = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   assign ctrl_wr = access_wr & (paddr == `SS_OFF_CTRL);

   // read mux and address check for the coming access phase
   always @*
   begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         `SS_OFF_CTRL:
         begin
            rd_nxt[`SS_CTRL_BITS-1:0] = ctrl_r;
         end
         `SS_OFF_RDATA:
         begin
            rd_nxt[`SS_RDATA_SP_MSB:`SS_RDATA_SP_LSB] = sp_data;
            rd_nxt[`SS_RDATA_DP_MSB:`SS_RDATA_DP_LSB] = dp_data;
         end
         `SS_OFF_STORE:
         begin
            rd_nxt[11:0] = store_q;
         end
         `SS_OFF_STATUS:
         begin
            rd_nxt[`SS_STAT_LUTS_MSB:`SS_STAT_LUTS_LSB] = luts_used;
            rd_nxt[`SS_STAT_CFG_OK] = cfg_ok;
         end
         default:
         begin
            err_nxt = 1'b1;
         end
      endcase
      if (pwrite && (paddr != `SS_OFF_CTRL))
      begin
         // only the control register is writable
         err_nxt = 1'b1;
         rd_nxt = 32'h0000_0000;
      end
   end

   // pready rises at the first edge after reset and stays: every access ends at once
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= 1'b1;
      end
   end

   // read data and error load at the setup edge and stand until the next setup
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= err_nxt;
      end
   end

   // control register write, taken at the access edge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `SS_CTRL_RESET;
      end
      else if (ctrl_wr)
      begin
         ctrl_r <= pwdata[`SS_CTRL_BITS-1:0];
      end
   end

endmodule // slice_lut_ram

// file: hdl/slice_storage_map.vh
// register offsets, field positions and reset values of the slice storage block
`ifndef SLICE_STORAGE_MAP_VH
`define SLICE_STORAGE_MAP_VH

// ====================================================================
// register byte offsets (apb, one aligned word each)
`define SS_OFF_CTRL 12'h000
`define SS_OFF_RDATA 12'h004
`define SS_OFF_STORE 12'h008
`define SS_OFF_STATUS 12'h00c

// ====================================================================
// control register fields
`define SS_CTRL_DEPTH_LSB 0
`define SS_CTRL_DEPTH_MSB 1
`define SS_CTRL_WIDTH_LSB 2
`define SS_CTRL_WIDTH_MSB 3
`define SS_CTRL_DUAL 4
`define SS_CTRL_REG_READ 5
`define SS_CTRL_SYNC_SET 6
`define SS_CTRL_SYNC_RST 7
`define SS_CTRL_ASYNC_PRE 8
`define SS_CTRL_ASYNC_CLR 9
`define SS_CTRL_BITS 10
`define SS_CTRL_RESET 10'h000

// ====================================================================
// read data register fields
`define SS_RDATA_SP_LSB 0
`define SS_RDATA_SP_MSB 7
`define SS_RDATA_DP_LSB 8
`define SS_RDATA_DP_MSB 11

// ====================================================================
// status register fields
`define SS_STAT_LUTS_LSB 0
`define SS_STAT_LUTS_MSB 3
`define SS_STAT_CFG_OK 4

// ====================================================================
// cluster size: lookup tables per cluster, words per table
`define SS_LUTS 8
`define SS_LUT_WORDS 16
`define SS_SP_MAX_LOG 3
`define SS_DP_MAX_LOG 2

`endif

// file: hdl/slice_store_elem.v
// slice storage element bank with configurable set, reset, preset and clear
`timescale 1ns/1ps

module slice_store_elem
#(
   parameter WIDTH = 12
)
(
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] d,
   input wire ce,
   input wire sync_set_en,
   input wire sync_rst_en,
   input wire async_pre_en,
   input wire async_clr_en,
   input wire set_in,
   input wire rst_in,
   input wire pre_in,
   input wire clr_in,
   output reg [WIDTH-1:0] q
);

   wire apre;
   wire aclr;

   // ====================================================================
   // asynchronous controls, gated by their enables
   // the enables are static configuration; changing them while the pin is
   // high can produce an edge on the async pin, so software must not do that
   assign apre = pre_in & async_pre_en;
   assign aclr = clr_in & async_clr_en;

   // ====================================================================
   // storage; clear beats preset, sync reset beats sync set
   // limitation: clear falling while preset stays high gives the preset only
   // at the next clock edge, since no new async edge arrives
   always @(posedge pclk or negedge presetn or posedge aclr or posedge apre)
   begin
      if (!presetn)
      begin
         q <= {WIDTH{1'b0}};
      end
      else if (aclr)
      begin
         q <= {WIDTH{1'b0}}; // [RULE_08] [RULE_10]
      end
      else if (apre)
      begin
         q <= {WIDTH{1'b1}}; // [RULE_08]
      end
      else if (sync_rst_en && rst_in)
      begin
         q <= {WIDTH{1'b0}}; // [RULE_08] [RULE_09]
      end
      else if (sync_set_en && set_in)
      begin
         q <= {WIDTH{1'b1}}; // [RULE_08]
      end
      else if (ce)
      begin
         q <= d;
      end
   end

endmodule // slice_store_elem

// file: test/slice_lut_ram_assertions.sv
// port checker for the slice storage block
`timescale 1ns/1ps
// ====
// checker on the top ports
module slice_lut_ram_checker
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire [11:0] store_d,
   input wire store_ce,
   input wire store_set,
   input wire store_reset,
   input wire store_preset,
   input wire store_clear,
   input wire [11:0] store_q
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg [9:0] ctrl_r;
   // option terms; a disabled pin must be ignored
   wire a_clr = ctrl_r[9] && store_clear;
   wire a_pre = ctrl_r[8] && store_preset;
   wire s_rst = ctrl_r[7] && store_reset;
   wire s_set = ctrl_r[6] && store_set;
   wire a_on = a_clr || a_pre;
   wire quiet = !a_on && !s_rst && !s_set;
   // shadow of the control word, since it is not a port
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= 10'h000;
      else if (psel && penable && pready && pwrite && paddr == 12'h000)
         ctrl_r <= pwdata[9:0];
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence bad_s;
      setup_s ##0 ((pwrite && paddr != 12'h000) || paddr > 12'h00c);
   endsequence
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access without ready");
   bad_access_a: assert property (bad_s |=> pslverr)
      else $error("bad access not flagged");
   async_clear_a: assert property (a_clr |-> store_q == 12'h000)
      else $error("clear lost");
   async_preset_a: assert property (a_pre && !a_clr |-> store_q == 12'hfff)
      else $error("preset lost");
   sync_reset_a: assert property (s_rst && !a_on |=> a_on || store_q == 12'h000)
      else $error("sync reset lost");
   sync_set_a: assert property (s_set && !s_rst && !a_on |=>
      a_on || store_q == 12'hfff)
      else $error("sync set lost");
   ce_load_a: assert property (!ctrl_r[5] && store_ce && quiet |=>
      a_on || store_q == $past(store_d))
      else $error("load lost");
   ce_hold_a: assert property (!ctrl_r[5] && !store_ce && quiet |=>
      a_on || $stable(store_q))
      else $error("hold lost");
endmodule // slice_lut_ram_checker

bind slice_lut_ram slice_lut_ram_checker slice_lut_ram_checker_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .store_d, .store_ce, .store_set,
   .store_reset, .store_preset, .store_clear, .store_q);

// file: test/slice_lut_ram_tb.sv
// self-checking bench for the slice storage block
`timescale 1ns/1ps
// ====
// bench top
module slice_lut_ram_tb;
   logic pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr, store_d;
   logic [31:0] pwdata, rd;
   logic store_ce, store_set, store_reset, store_preset, store_clear;
   wire [31:0] prdata;
   wire pready, pslverr, wr_en;
   wire [6:0] ram_addr;
   wire [5:0] ram_rd_addr;
   wire [7:0] ram_wdata;
   wire [11:0] store_q;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   user_logic_model user_logic_model_inst (.pclk, .ram_addr, .ram_rd_addr, .ram_wdata, .wr_en);
   slice_lut_ram slice_lut_ram_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ram_addr, .ram_rd_addr, .ram_wdata,
      .slice_set_reset_input(wr_en), .store_d, .store_ce, .store_set, .store_reset,
      .store_preset, .store_clear, .store_q);
   // 40 MHz clock
   initial
   begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer; data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic look(input logic [6:0] a, input logic [5:0] r);
      user_logic_model_inst.point(a, r);
      apb(1'h0, 12'h004, 32'h0);
   endtask
   task automatic st(input logic [3:0] m, input logic [11:0] e);
      @(posedge pclk);
      {store_set, store_reset, store_preset, store_clear} <= m;
      @(posedge pclk);
      #1 chk(store_q, e);
   endtask
   // ====
   // scenarios
   task automatic t_regs();
      int v, l;
      apb(1'h1, 12'h004, 32'hff);
      chk(err, 32'h1);
      apb(1'h0, 12'h010, 32'h0);
      chk(err, 32'h1);
      for (int c = 0; c < 32; c++)
      begin
         v = (c[4] ? 2 : 3) >= c[1:0] + c[3:2];
         l = (1 << (c[1:0] + c[3:2])) << c[4];
         apb(1'h1, 12'h000, c);
         apb(1'h0, 12'h00c, 32'h0);
         chk(rd & (v ? 32'h1f : 32'h10), v ? 16 + l : 0);
      end
      $display("regs and shapes done");
   endtask
   task automatic t_ram();
      apb(1'h1, 12'h000, 32'h0c);
      user_logic_model_inst.wr(7'h05, 8'ha5);
      user_logic_model_inst.wr(7'h06, 8'h3c);
      look(7'h05, 6'h0);
      chk(rd & 32'hff, 32'ha5);
      look(7'h06, 6'h0);
      chk(rd & 32'hff, 32'h3c);
      apb(1'h1, 12'h000, 32'h18);
      user_logic_model_inst.wr(7'h03, 8'h09);
      user_logic_model_inst.wr(7'h04, 8'h06);
      look(7'h04, 6'h03);
      chk(rd & 32'hf0f, 32'h906);
      apb(1'h1, 12'h000, 32'h12);
      user_logic_model_inst.wr(7'h3f, 8'h01);
      user_logic_model_inst.wr(7'h00, 8'h00);
      look(7'h00, 6'h3f);
      chk(rd & 32'h101, 32'h100);
      apb(1'h1, 12'h000, 32'h03);
      user_logic_model_inst.wr(7'h7f, 8'h01);
      user_logic_model_inst.wr(7'h0f, 8'h00);
      look(7'h7f, 6'h0);
      chk(rd & 32'h1, 32'h1);
      look(7'h0f, 6'h0);
      chk(rd & 32'h1, 32'h0);
      // 32x4: two banks share word 14, so a bank mix-up shows
      apb(1'h1, 12'h000, 32'h09);
      user_logic_model_inst.wr(7'h1e, 8'h0c);
      user_logic_model_inst.wr(7'h0e, 8'h03);
      look(7'h1e, 6'h0);
      chk(rd & 32'hff, 32'h0c);
      look(7'h0e, 6'h0);
      chk(rd & 32'hff, 32'h03);
      $display("memory done");
   endtask
   task automatic t_store();
      apb(1'h1, 12'h000, 32'h2c);
      user_logic_model_inst.wr(7'h07, 8'h5a);
      user_logic_model_inst.point(7'h07, 6'h0);
      @(posedge pclk);
      #1 chk(store_q & 12'hff, 32'h5a);
      apb(1'h1, 12'h000, 32'h3c0);
      st(4'hc, 12'h000);
      st(4'h8, 12'hfff);
      st(4'h3, 12'h000);
      // drop both pins so the preset alone arrives as a fresh async edge
      st(4'h0, 12'h000);
      st(4'h2, 12'hfff);
      apb(1'h1, 12'h000, 32'h0);
      store_d <= 12'h3a5;
      store_ce <= 1'h1;
      st(4'h0, 12'h3a5);
      $display("storage done");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   // reset, then scenarios
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, store_d} = '0;
      {store_ce, store_set, store_reset, store_preset, store_clear} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_ram();
      t_store();
      tally_and_finish();
   end
endmodule // slice_lut_ram_tb

// file: test/user_logic_model.sv
// model of the user logic on the memory port
`timescale 1ns/1ps
// ====
// memory port driver
module user_logic_model
(
   input wire pclk,
   output logic [6:0] ram_addr,
   output logic [5:0] ram_rd_addr,
   output logic [7:0] ram_wdata,
   output logic wr_en
);
   // quiet port at time zero
   initial
   begin
      ram_addr = 7'h00;
      ram_rd_addr = 6'h00;
      ram_wdata = 8'h00;
      wr_en = 1'h0;
   end
   // one write, then data turned round so a held value proves nothing
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge pclk);
      ram_addr <= a;
      ram_wdata <= d;
      wr_en <= 1'h1;
      @(posedge pclk);
      wr_en <= 1'h0;
      ram_wdata <= ~d;
   endtask
   // steer both read addresses
   task automatic point(input logic [6:0] a, input logic [5:0] r);
      @(posedge pclk);
      ram_addr <= a;
      ram_rd_addr <= r;
   endtask
endmodule // user_logic_model
